// ---- verilog/vfs_pkg.sv ----
package vfs_pkg;
	localparam int SAMPLE_W = 8;
	localparam int PLANES   = 3;
	localparam int DIM_W    = 12;
	localparam int LINE_MAX = 1024;
	localparam int FRAC_H   = 4;
	localparam int FRAC_V   = 3;
	localparam int FRAC_T   = FRAC_H + FRAC_V;
	localparam int MULT_W   = (SAMPLE_W > FRAC_T + 2) ? SAMPLE_W : FRAC_T + 2;
	localparam int ERR_W    = ((FRAC_H > FRAC_V) ? FRAC_H : FRAC_V) + 1;
	localparam int PROD_W   = 2 * MULT_W;
	localparam int SUM_W    = PROD_W + 2;
	localparam int TAPS     = 4;
	localparam int BUF_DEPTH = 2;

	localparam logic [ERR_W-1:0]  FULL_H   = ERR_W'(1 << FRAC_H);
	localparam logic [ERR_W-1:0]  FULL_V   = ERR_W'(1 << FRAC_V);
	localparam logic [MULT_W+1:0] WGT_FULL = (MULT_W + 2)'(1 << FRAC_T);
	localparam logic [DIM_W-1:0]  DIM_RST  = 12'h000;
	localparam logic [1:0]        CNT_RST  = 2'h0;

	typedef enum logic [1:0] {VFS_NEAREST, VFS_BILINEAR, VFS_BICUBIC, VFS_POLYPHASE} vfs_mode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_DROP, ST_CAPTURE, ST_EMIT} vfs_state_t;

	typedef logic [PLANES-1:0][SAMPLE_W-1:0] vfs_pixel_t;

	typedef struct packed {
		logic       sof;
		logic       eol;
		vfs_pixel_t data;
	} vfs_beat_t;

	typedef struct packed {
		vfs_mode_t        mode;
		logic [DIM_W-1:0] in_w;
		logic [DIM_W-1:0] in_h;
		logic [DIM_W-1:0] clip_x;
		logic [DIM_W-1:0] clip_y;
		logic [DIM_W-1:0] clip_w;
		logic [DIM_W-1:0] clip_h;
		logic [DIM_W-1:0] out_w;
		logic [DIM_W-1:0] out_h;
	} vfs_cfg_t;

	localparam vfs_cfg_t CFG_RST = '0;
endpackage : vfs_pkg

// ---- verilog/vfs_scaler.sv ----
// How it works
// - Resizes and clips frames; mode chosen per frame from the configuration input.
// - Output size and settings may be changed by the controller between frames; they are sampled only at frame start.
// - Nearest mode copies one selected input pixel, no blending, no multipliers.
// - Nearest downscale uses no line memory; nearest upscale uses one line buffer.
// - Line buffer holds sample bits times planes times clipped width.
// - Nearest picks input pixel nearest to the half-pixel-centred scaled position.
// - Nearest source index is (2*win*i + win) / (2*wout), truncated.
// - Bilinear uses four parallel multipliers per colour plane.
// - Multiplier width is max(sample width, fraction bits sum plus 2).
// - Bilinear keeps two line buffers of one clipped line each.
// - Integer part of scaled coordinate gives top-left of the 2x2 neighbourhood.
// - Fraction errors are remainder times 2^bits over max of dimensions.
// - Top-left weighted by full minus error, neighbours by errors, summed and scaled.
`timescale 1ns/1ps
module vfs_scaler
	import vfs_pkg::*;
(
	input  wire logic      MCLK_I,
	input  wire logic      RST_N_I,
	input  wire vfs_cfg_t  CFG_I,
	input  wire logic      IN_VALID_I,
	input  wire vfs_beat_t IN_BEAT_I,
	output logic           IN_READY_O,
	output logic           OUT_VALID_O,
	output vfs_beat_t      OUT_BEAT_O,
	input  wire logic      OUT_READY_I
);

	function automatic logic [DIM_W-1:0] nn_src(input logic [DIM_W-1:0] k, input logic [DIM_W-1:0] win,
		input logic [DIM_W-1:0] wout);
		nn_src = DIM_W'((2 * int'(win) * int'(k) + int'(win)) / (2 * int'(wout)));
	endfunction : nn_src

	function automatic logic [DIM_W-1:0] bil_int(input logic [DIM_W-1:0] k, input logic [DIM_W-1:0] win,
		input logic [DIM_W-1:0] wout);
		bil_int = DIM_W'((int'(k) * int'(win)) / int'(wout));
	endfunction : bil_int

	function automatic logic [ERR_W-1:0] bil_err(input logic [DIM_W-1:0] k, input logic [DIM_W-1:0] win,
		input logic [DIM_W-1:0] wout, input int fb);
		bil_err = ERR_W'((((int'(k) * int'(win)) % int'(wout)) << fb) / ((win > wout) ? int'(win) : int'(wout)));
	endfunction : bil_err

	vfs_state_t       st_r;
	vfs_state_t       st_nxt;
	vfs_cfg_t         cfg_r;
	logic [DIM_W-1:0] row_r;
	logic [DIM_W-1:0] col_r;
	logic [DIM_W-1:0] last_cr_r;
	logic             last_row_r;
	logic [DIM_W-1:0] oi_r;
	logic [DIM_W-1:0] oj_r;
	logic             in_ready_r;
	vfs_pixel_t       lbuf_r [2][LINE_MAX];
	logic             s1_v_r;
	logic             s1_nn_r;
	logic             s1_sof_r;
	logic             s1_eol_r;
	logic [DIM_W-1:0] s1_x_r;
	vfs_pixel_t       s1_p_r [TAPS];
	logic [ERR_W-1:0] s1_ex_r;
	logic [ERR_W-1:0] s1_ey_r;
	logic [1:0]       cnt_r;
	logic [1:0]       cnt_nxt;
	logic             out_valid_r;
	vfs_beat_t        head_r;
	vfs_beat_t        spare_r;

	logic             nn;
	logic             nn_down;
	logic             acc;
	logic             in_clip_row;
	logic             in_clip;
	logic [DIM_W-1:0] cr;
	logic [DIM_W-1:0] cc;
	logic             eor;
	logic             we;
	logic             wsel;
	logic             down_hit;
	logic [DIM_W-1:0] need_row;
	logic             row_ready;
	logic             emit_issue;
	logic             issue;
	logic             pop;
	logic             push;
	logic [2:0]       occ;
	logic             can_issue;
	logic [DIM_W-1:0] sx;
	logic [DIM_W-1:0] sy;
	logic [DIM_W-1:0] ix;
	logic [DIM_W-1:0] iy;
	logic [DIM_W-1:0] x1;
	logic [DIM_W-1:0] ybot;
	vfs_beat_t        res;

	assign nn          = (cfg_r.mode == VFS_NEAREST);
	assign nn_down     = nn && (cfg_r.out_w <= cfg_r.clip_w) && (cfg_r.out_h <= cfg_r.clip_h);
	assign acc         = IN_VALID_I && in_ready_r && (st_r == ST_CAPTURE);
	assign in_clip_row = (row_r >= cfg_r.clip_y) && (row_r < cfg_r.clip_y + cfg_r.clip_h);
	assign in_clip     = in_clip_row && (col_r >= cfg_r.clip_x) && (col_r < cfg_r.clip_x + cfg_r.clip_w);
	assign cr          = row_r - cfg_r.clip_y;
	assign cc          = col_r - cfg_r.clip_x;
	assign eor         = acc && (col_r == cfg_r.in_w - 12'h001);
	assign we          = acc && in_clip && !nn_down;
	assign wsel        = nn ? 1'b0 : cr[0];

	// Coordinates use the clipped size as the input dimensions
	assign sx   = nn_src(oi_r, cfg_r.clip_w, cfg_r.out_w);
	assign sy   = nn_src(oj_r, cfg_r.clip_h, cfg_r.out_h);
	assign ix   = bil_int(oi_r, cfg_r.clip_w, cfg_r.out_w);
	assign iy   = bil_int(oj_r, cfg_r.clip_h, cfg_r.out_h);
	assign x1   = (ix + 12'h001 < cfg_r.clip_w) ? ix + 12'h001 : cfg_r.clip_w - 12'h001;
	assign ybot = (iy + 12'h001 < cfg_r.clip_h) ? iy + 12'h001 : cfg_r.clip_h - 12'h001;

	assign down_hit   = acc && in_clip && nn_down && (oj_r < cfg_r.out_h) && (cr == sy) && (cc == sx);
	assign need_row   = nn ? sy : ybot;
	assign row_ready  = (oj_r < cfg_r.out_h) && (need_row == last_cr_r);
	assign pop        = out_valid_r && OUT_READY_I;
	assign push       = s1_v_r;
	assign occ        = 3'({1'b0, cnt_r}) + 3'({2'b00, s1_v_r});
	assign can_issue  = occ < 3'({2'b01, pop});
	assign emit_issue = (st_r == ST_EMIT) && row_ready && can_issue;
	assign issue      = down_hit || emit_issue;
	assign cnt_nxt    = 2'(cnt_r + {1'b0, push} - {1'b0, pop});

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (IN_VALID_I) begin
					st_nxt = IN_BEAT_I.sof ? ST_CAPTURE : ST_DROP;
				end
			end
			ST_DROP: begin
				st_nxt = ST_IDLE;
			end
			ST_CAPTURE: begin
				if (eor) begin
					if (in_clip_row && !nn_down) begin
						st_nxt = ST_EMIT;
					end else if (row_r == cfg_r.in_h - 12'h001) begin
						st_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				if (!row_ready) begin
					st_nxt = last_row_r ? ST_IDLE : ST_CAPTURE;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_r       <= ST_IDLE;
			in_ready_r <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			in_ready_r <= (st_nxt == ST_DROP) || ((st_nxt == ST_CAPTURE) && (3'({1'b0, cnt_nxt}) + 3'({2'b00, issue}) <= 3'h1));
		end
	end

	// Settings are sampled only while waiting for a frame start
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cfg_r <= CFG_RST;
		end else if ((st_r == ST_IDLE) && IN_VALID_I && IN_BEAT_I.sof) begin
			cfg_r <= CFG_I;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			row_r      <= DIM_RST;
			col_r      <= DIM_RST;
			last_cr_r  <= DIM_RST;
			last_row_r <= 1'b0;
		end else if (st_r == ST_IDLE) begin
			row_r      <= DIM_RST;
			col_r      <= DIM_RST;
			last_row_r <= 1'b0;
		end else if (eor) begin
			col_r      <= DIM_RST;
			row_r      <= row_r + 12'h001;
			last_cr_r  <= cr;
			last_row_r <= (row_r == cfg_r.in_h - 12'h001);
		end else if (acc) begin
			col_r <= col_r + 12'h001;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (we) begin
			lbuf_r[wsel][cc[$clog2(LINE_MAX)-1:0]] <= IN_BEAT_I.data;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			oi_r <= DIM_RST;
			oj_r <= DIM_RST;
		end else if (st_r == ST_IDLE) begin
			oi_r <= DIM_RST;
			oj_r <= DIM_RST;
		end else if (issue) begin
			if (oi_r == cfg_r.out_w - 12'h001) begin
				oi_r <= DIM_RST;
				oj_r <= oj_r + 12'h001;
			end else begin
				oi_r <= oi_r + 12'h001;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s1_v_r   <= 1'b0;
			s1_nn_r  <= 1'b0;
			s1_sof_r <= 1'b0;
			s1_eol_r <= 1'b0;
			s1_x_r   <= DIM_RST;
			s1_ex_r  <= '0;
			s1_ey_r  <= '0;
			for (int t = 0; t < TAPS; t++) begin
				s1_p_r[t] <= '0;
			end
		end else begin
			s1_v_r <= issue;
			if (issue) begin
				s1_nn_r  <= nn;
				s1_sof_r <= (oi_r == DIM_RST) && (oj_r == DIM_RST);
				s1_eol_r <= (oi_r == cfg_r.out_w - 12'h001);
				s1_x_r   <= nn ? sx : ix;
				s1_ex_r  <= bil_err(oi_r, cfg_r.clip_w, cfg_r.out_w, FRAC_H);
				s1_ey_r  <= bil_err(oj_r, cfg_r.clip_h, cfg_r.out_h, FRAC_V);
				if (down_hit) begin
					s1_p_r[0] <= IN_BEAT_I.data;
				end else if (nn) begin
					s1_p_r[0] <= lbuf_r[0][sx[$clog2(LINE_MAX)-1:0]];
				end else begin
					s1_p_r[0] <= lbuf_r[iy[0]][ix[$clog2(LINE_MAX)-1:0]];
					s1_p_r[1] <= lbuf_r[iy[0]][x1[$clog2(LINE_MAX)-1:0]];
					s1_p_r[2] <= lbuf_r[ybot[0]][ix[$clog2(LINE_MAX)-1:0]];
					s1_p_r[3] <= lbuf_r[ybot[0]][x1[$clog2(LINE_MAX)-1:0]];
				end
			end
		end
	end

	// Bilinear weights and one multiplier per tap and plane
	logic [MULT_W-1:0] wgt [TAPS];
	logic [MULT_W+1:0] wgt_sum;
	assign wgt[0]  = MULT_W'((FULL_H - s1_ex_r) * (FULL_V - s1_ey_r));
	assign wgt[1]  = MULT_W'(s1_ex_r * (FULL_V - s1_ey_r));
	assign wgt[2]  = MULT_W'((FULL_H - s1_ex_r) * s1_ey_r);
	assign wgt[3]  = MULT_W'(s1_ex_r * s1_ey_r);
	assign wgt_sum = (MULT_W + 2)'(wgt[0]) + (MULT_W + 2)'(wgt[1]) + (MULT_W + 2)'(wgt[2]) + (MULT_W + 2)'(wgt[3]);

	logic [PROD_W-1:0] prod [PLANES][TAPS];
	logic [SUM_W-1:0]  psum [PLANES];
	vfs_pixel_t        blend;
	for (genvar p = 0; p < PLANES; p++) begin : g_plane
		for (genvar t = 0; t < TAPS; t++) begin : g_tap
			assign prod[p][t] = MULT_W'(s1_p_r[t][p]) * wgt[t];
		end
		assign psum[p]  = SUM_W'(prod[p][0]) + SUM_W'(prod[p][1]) + SUM_W'(prod[p][2]) + SUM_W'(prod[p][3]);
		assign blend[p] = psum[p][FRAC_T +: SAMPLE_W];
	end

	assign res.sof  = s1_sof_r;
	assign res.eol  = s1_eol_r;
	assign res.data = s1_nn_r ? s1_p_r[0] : blend;

	// Two-entry output buffer; the head register drives the sink directly
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cnt_r       <= CNT_RST;
			out_valid_r <= 1'b0;
			head_r      <= '0;
			spare_r     <= '0;
		end else begin
			cnt_r       <= cnt_nxt;
			out_valid_r <= (cnt_nxt != CNT_RST);
			if (push && ((cnt_r == 2'h0) || ((cnt_r == 2'h1) && pop))) begin
				head_r <= res;
			end else if (push && (cnt_r == 2'h1)) begin
				spare_r <= res;
			end else if ((cnt_r == 2'h2) && pop) begin
				head_r <= spare_r;
				if (push) begin
					spare_r <= res;
				end
			end
		end
	end

	assign IN_READY_O  = in_ready_r;
	assign OUT_VALID_O = out_valid_r;
	assign OUT_BEAT_O  = head_r;

	a_nn_copy_pixel: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		push && s1_nn_r && (cnt_r == 2'h0) |=> OUT_BEAT_O.data == $past(s1_p_r[0]))
		else $error("nearest output is not a copy of the selected pixel");
	a_nn_one_buffer: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		we && nn |-> !wsel)
		else $error("nearest mode wrote the second line buffer");
	a_nn_down_nomem: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		nn_down |-> !we && st_r != ST_EMIT)
		else $error("nearest downscale wrote line memory");
	a_nn_column: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		issue && nn |=> s1_x_r == DIM_W'((2 * int'(cfg_r.clip_w) * int'($past(oi_r)) + int'(cfg_r.clip_w))
			/ (2 * int'(cfg_r.out_w))))
		else $error("nearest source column wrong");
	a_bil_corner: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		issue && !nn |=> s1_x_r == DIM_W'((int'($past(oi_r)) * int'(cfg_r.clip_w)) / int'(cfg_r.out_w)))
		else $error("bilinear top-left column wrong");
	a_bil_weights: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		s1_v_r && !s1_nn_r |-> wgt_sum == WGT_FULL && s1_ex_r < FULL_H && s1_ey_r < FULL_V)
		else $error("bilinear weights do not sum to full scale");
	a_cfg_frame_edge: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		cfg_r != $past(cfg_r) |-> $past(st_r) == ST_IDLE && $past(IN_BEAT_I.sof))
		else $error("settings changed inside a frame");
	a_clip_discard: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(we || down_hit) |-> in_clip && cc < cfg_r.clip_w && cr < cfg_r.clip_h)
		else $error("pixel outside clip window used");
	a_buf_no_ovf: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		cnt_r == 2'h2 && !pop |-> !push ##1 cnt_r == 2'h2)
		else $error("output buffer overflow");

endmodule : vfs_scaler

// ---- dv/vfs_sink_model.sv ----
`timescale 1ns/1ps
module vfs_sink_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [1:0] stall_i,
	output logic            ready_o
);
	// 0: always ready, 1: random half stall, 2: mostly stalled so the buffer fills
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ready_o <= 1'b0;
		else if (stall_i == 2'h0)
			ready_o <= #1 1'b1;
		else if (stall_i == 2'h1)
			ready_o <= #1 1'($urandom % 2);
		else
			ready_o <= #1 (($urandom % 8) == 0);
	end
endmodule : vfs_sink_model

// ---- dv/vfs_scaler_bench.sv ----
`timescale 1ns/1ps
module vfs_scaler_bench
	import vfs_pkg::*;
;
	logic       MCLK_I;
	logic       RST_N_I;
	vfs_cfg_t   CFG_I;
	logic       IN_VALID_I;
	vfs_beat_t  IN_BEAT_I;
	logic       IN_READY_O;
	logic       OUT_VALID_O;
	vfs_beat_t  OUT_BEAT_O;
	logic       OUT_READY_I;
	logic [1:0] stall;
	vfs_beat_t  exp_q[$];
	vfs_pixel_t img[8][8];
	int         fails;
	int         n_compared;

	vfs_scaler dut (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CFG_I(CFG_I), .IN_VALID_I(IN_VALID_I),
		.IN_BEAT_I(IN_BEAT_I), .IN_READY_O(IN_READY_O), .OUT_VALID_O(OUT_VALID_O),
		.OUT_BEAT_O(OUT_BEAT_O), .OUT_READY_I(OUT_READY_I));
	vfs_sink_model sink (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .stall_i(stall), .ready_o(OUT_READY_I));

	initial begin
		MCLK_I = 1'b0;
		forever #20 MCLK_I = ~MCLK_I;
	end

	task automatic final_report();
		$display("Checks: n_compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	task automatic check(input string nm, input logic [$bits(vfs_beat_t)-1:0] seen,
		input logic [$bits(vfs_beat_t)-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Scoreboard: every pixel the sink accepts is matched against the oldest note
	always @(posedge MCLK_I) begin
		if (RST_N_I === 1'b1 && OUT_VALID_O === 1'b1 && OUT_READY_I === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("[FAIL] out_beat expected none seen %h", OUT_BEAT_O);
			end else
				check("out_beat", OUT_BEAT_O, exp_q.pop_front());
		end
	end

	// Holds the beat until the edge at which ready is sampled high
	task automatic put_beat(input vfs_beat_t b);
		int   n;
		logic rdy;
		IN_BEAT_I = b;
		IN_VALID_I = 1'b1;
		n = 0;
		do begin
			rdy = IN_READY_O;
			@(posedge MCLK_I);
			#1;
			n++;
		end while (rdy !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			fails++;
			final_report();
		end
	endtask : put_beat

	function automatic vfs_cfg_t mk(vfs_mode_t m, int cx, int cy, int cw, int ch, int ow, int oh);
		vfs_cfg_t c;
		c = '{m, 12'h008, 12'h006, DIM_W'(cx), DIM_W'(cy), DIM_W'(cw), DIM_W'(ch), DIM_W'(ow), DIM_W'(oh)};
		return c;
	endfunction : mk

	task automatic run_frame(input vfs_cfg_t c, input logic [1:0] st);
		int        cw, ch, ow, oh, sx, sy, x1, y1, eh, ev, acc, n;
		vfs_beat_t e;
		vfs_beat_t b;
		cw = int'(c.clip_w);
		ch = int'(c.clip_h);
		ow = int'(c.out_w);
		oh = int'(c.out_h);
		stall = st;
		for (int y = 0; y < 6; y++)
			for (int x = 0; x < 8; x++)
				img[y][x] = vfs_pixel_t'({$urandom, $urandom});
		for (int j = 0; j < oh; j++) begin
			for (int i = 0; i < ow; i++) begin
				e.sof = (i == 0 && j == 0);
				e.eol = (i == ow - 1);
				if (c.mode == VFS_NEAREST) begin
					sx = (2 * cw * i + cw) / (2 * ow);
					sy = (2 * ch * j + ch) / (2 * oh);
					e.data = img[c.clip_y + sy][c.clip_x + sx];
				end else begin
					sx = (i * cw) / ow;
					sy = (j * ch) / oh;
					eh = ((i * cw) % ow) * (1 << FRAC_H) / ((cw > ow) ? cw : ow);
					ev = ((j * ch) % oh) * (1 << FRAC_V) / ((ch > oh) ? ch : oh);
					x1 = (sx + 1 < cw) ? sx + 1 : cw - 1;
					y1 = (sy + 1 < ch) ? sy + 1 : ch - 1;
					sx += int'(c.clip_x);
					x1 += int'(c.clip_x);
					sy += int'(c.clip_y);
					y1 += int'(c.clip_y);
					for (int p = 0; p < PLANES; p++) begin
						acc = img[sy][sx][p] * ((1 << FRAC_H) - eh) * ((1 << FRAC_V) - ev)
							+ img[sy][x1][p] * eh * ((1 << FRAC_V) - ev)
							+ img[y1][sx][p] * ((1 << FRAC_H) - eh) * ev
							+ img[y1][x1][p] * eh * ev;
						e.data[p] = SAMPLE_W'(acc >> FRAC_T);
					end
				end
				exp_q.push_back(e);
			end
		end
		CFG_I = c;
		for (int y = 0; y < 6; y++) begin
			for (int x = 0; x < 8; x++) begin
				b.sof = (x == 0 && y == 0);
				b.eol = (x == 7);
				b.data = img[y][x];
				put_beat(b);
				// Settings change mid-frame must not reach this frame
				if (b.sof)
					CFG_I = ~c;
			end
		end
		IN_VALID_I = 1'b0;
		IN_BEAT_I = ~b;
		n = 0;
		while (exp_q.size() != 0 && n < 6000) begin
			@(posedge MCLK_I);
			n++;
		end
		#1;
		if (n >= 6000) begin
			fails++;
			final_report();
		end
	endtask : run_frame

	initial begin
		vfs_beat_t d;
		fails = 0;
		n_compared = 0;
		RST_N_I = 1'b0;
		IN_VALID_I = 1'b0;
		IN_BEAT_I = '0;
		CFG_I = CFG_RST;
		stall = 2'h0;
		void'($urandom(32'h368e_6d9c));
		repeat (6) @(posedge MCLK_I);
		#1;
		check("in_ready_rst", IN_READY_O, 1'b0);
		check("out_valid_rst", OUT_VALID_O, 1'b0);
		check("out_beat_rst", OUT_BEAT_O, '0);
		RST_N_I = 1'b1;
		@(posedge MCLK_I);
		#1;
		check("out_valid_rel", OUT_VALID_O, 1'b0);
		// A stray beat without frame start is dropped while idle
		d = '{1'b0, 1'b0, vfs_pixel_t'({$urandom, $urandom})};
		put_beat(d);
		IN_VALID_I = 1'b0;
		run_frame(mk(VFS_NEAREST, 1, 1, 6, 4, 3, 2), 2'h1);
		run_frame(mk(VFS_NEAREST, 0, 0, 5, 3, 9, 5), 2'h2);
		run_frame(mk(VFS_BILINEAR, 2, 1, 5, 4, 7, 6), 2'h1);
		run_frame(mk(VFS_BICUBIC, 0, 0, 8, 6, 5, 4), 2'h0);
		run_frame(mk(VFS_POLYPHASE, 0, 0, 3, 3, 5, 5), 2'h2);
		run_frame(mk(VFS_BILINEAR, 1, 0, 7, 6, 4, 3), 2'h1);
		run_frame(mk(VFS_NEAREST, 0, 0, 8, 6, 8, 6), 2'h0);
		final_report();
	end
endmodule : vfs_scaler_bench
